// >>> design/exec_pkg.sv
package exec_pkg;

  // Register byte offsets on the slave port
  localparam logic [4:0] OPCODE_OFF = 5'h00;
  localparam logic [4:0] OPERAND_OFF = 5'h04;
  localparam logic [4:0] ACC_OFF = 5'h08;
  localparam logic [4:0] INDEX_OFF = 5'h0c;
  localparam logic [4:0] FLAGS_OFF = 5'h10;
  localparam logic [4:0] STATUS_OFF = 5'h14;
  localparam logic [4:0] MADDR_OFF = 5'h18;
  localparam logic [4:0] MDATA_OFF = 5'h1c;

  // Condition flag positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam int FLG_H = 4;

  // Status word layout
  localparam int STAT_BYTES_LSB = 0;
  localparam int STAT_CYC_LSB = 2;
  localparam int STAT_ILL_BIT = 6;
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_RES_LSB = 8;

  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] INDEX_RST = 8'h00;
  localparam logic [15:0] OPERAND_RST = 16'h0000;
  localparam logic [7:0] MADDR_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h08;
  localparam logic [7:0] OPCODE_RST = 8'h9d;

  // Opcode low nibbles per operation
  localparam logic [3:0] LD_LO = 4'he;
  localparam logic [3:0] SHL_LO = 4'h8;
  localparam logic [3:0] TWOS_LO = 4'h0;

  // Opcode high nibbles per addressing form
  localparam logic [3:0] HI_IMM = 4'ha;
  localparam logic [3:0] HI_DIR = 4'hb;
  localparam logic [3:0] HI_EXT = 4'hc;
  localparam logic [3:0] HI_IX16 = 4'hd;
  localparam logic [3:0] HI_IX8 = 4'he;
  localparam logic [3:0] HI_IX0 = 4'hf;
  localparam logic [3:0] HI_RMW_DIR = 4'h3;
  localparam logic [3:0] HI_ACC = 4'h4;
  localparam logic [3:0] HI_IDX = 4'h5;
  localparam logic [3:0] HI_RMW_IX8 = 4'h6;
  localparam logic [3:0] HI_RMW_IX0 = 4'h7;

  // Cycle counts
  localparam logic [2:0] LD_IMM_CYC = 3'h2;
  localparam logic [2:0] LD_DIR_CYC = 3'h3;
  localparam logic [2:0] LD_EXT_CYC = 3'h4;
  localparam logic [2:0] LD_IX0_CYC = 3'h3;
  localparam logic [2:0] LD_IX8_CYC = 3'h4;
  localparam logic [2:0] LD_IX16_CYC = 3'h5;
  localparam logic [2:0] RMW_REG_CYC = 3'h3;
  localparam logic [2:0] RMW_DIR_CYC = 3'h5;
  localparam logic [2:0] RMW_IX0_CYC = 3'h5;
  localparam logic [2:0] RMW_IX8_CYC = 3'h6;

  // Instruction lengths
  localparam logic [1:0] ONE_BYTE = 2'h1;
  localparam logic [1:0] TWO_BYTES = 2'h2;
  localparam logic [1:0] THREE_BYTES = 2'h3;

  typedef enum logic [1:0] {OP_NONE, OP_LOAD, OP_SHIFT, OP_TWOS} op_t;
  typedef enum logic [2:0] {M_IMM, M_DIR, M_EXT, M_IX0, M_IX8, M_IX16, M_ACC, M_IDX} mode_t;
  typedef enum logic {ST_IDLE, ST_EXEC} exec_state_t;

  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction : is_zero

endpackage : exec_pkg

// >>> design/exec_slice.sv
// What this block does
// RULE1: Load index copies memory byte, sets N Z
// RULE2: Load index opcodes, lengths and cycle counts
// RULE3: Shift left inserts zero, old bit7 to carry
// RULE4: Logical and arithmetic shift are identical
// RULE5: Shift left opcodes, lengths and cycle counts
// RULE6: Negate result is zero minus operand
// RULE7: Negate carry set unless operand was zero
// RULE8: Negative flag equals result bit seven
// RULE9: Zero flag set when result is zero
// RULE10: Negate opcodes, lengths and cycle counts
// RULE11: H and I kept; memory forms write back
module exec_slice (
  input logic clk_in,
  input logic resetn_in,
  input logic [4:0] avs_address_in,
  input logic avs_read_in,
  input logic avs_write_in,
  input logic [31:0] avs_writedata_in,
  input logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out
);

  exec_pkg::exec_state_t state_ff;
  exec_pkg::op_t op_ff;
  exec_pkg::mode_t mode_ff;
  exec_pkg::op_t dec_op;
  exec_pkg::mode_t dec_mode;
  logic [2:0] cnt_ff;
  logic [2:0] cyc_ff;
  logic [2:0] run_len_ff;
  logic [1:0] bytes_ff;
  logic illegal_ff;
  logic [7:0] opc_ff;
  logic [7:0] acc_ff;
  logic [7:0] index_ff;
  logic [7:0] result_ff;
  logic [7:0] maddr_ff;
  logic [4:0] flags_ff;
  logic [4:0] nxt_flags;
  logic [15:0] operand_ff;
  logic [15:0] ea_ff;
  logic [15:0] ea_w;
  logic [1:0] dec_bytes;
  logic [2:0] dec_cyc;
  logic dec_legal;
  logic [7:0] oper_w;
  logic [7:0] res_w;
  logic n_w;
  logic z_w;
  logic c_w;
  logic c_upd_w;
  logic [31:0] status_w;
  logic [31:0] rd_mux_w;
  // Small data store; effective addresses wrap to its size
  logic [7:0] mem_q [0:255];

  // Bus handshake: reads allowed while busy, writes wait for idle
  wire idle_w = state_ff == exec_pkg::ST_IDLE;
  wire req_w = avs_read_in || avs_write_in;
  wire accept_w = req_w && avs_waitrequest_out && (idle_w || avs_read_in);
  wire xfer_w = req_w && !avs_waitrequest_out;
  wire wr_w = avs_write_in && xfer_w;
  wire wr0_w = wr_w && avs_byteenable_in[0];
  wire wr1_w = wr_w && avs_byteenable_in[1];
  wire start_w = wr0_w && avs_address_in == exec_pkg::OPCODE_OFF;
  wire go_w = start_w && dec_legal;
  wire commit_w = !idle_w && cnt_ff == 3'h0;
  wire is_load_w = op_ff == exec_pkg::OP_LOAD;
  wire reg_mode_w = mode_ff == exec_pkg::M_ACC || mode_ff == exec_pkg::M_IDX;
  wire to_acc_w = commit_w && mode_ff == exec_pkg::M_ACC;
  wire to_idx_w = commit_w && (is_load_w || mode_ff == exec_pkg::M_IDX); // [RULE1]
  wire to_mem_w = commit_w && !is_load_w && !reg_mode_w; // [RULE11]

  opcode_decode opcode_decode_i (
    .opc_in(avs_writedata_in[7:0]),
    .op_out(dec_op),
    .mode_out(dec_mode),
    .bytes_out(dec_bytes),
    .cyc_out(dec_cyc),
    .legal_out(dec_legal)
  );

  // Address formed at issue; index cannot change until commit
  assign ea_w = dec_mode == exec_pkg::M_EXT ? operand_ff :
                dec_mode == exec_pkg::M_IX0 ? {8'h00, index_ff} :
                dec_mode == exec_pkg::M_IX8 ? {8'h00, index_ff} + {8'h00, operand_ff[7:0]} :
                dec_mode == exec_pkg::M_IX16 ? {8'h00, index_ff} + operand_ff :
                {8'h00, operand_ff[7:0]};

  assign oper_w = mode_ff == exec_pkg::M_ACC ? acc_ff :
                  mode_ff == exec_pkg::M_IDX ? index_ff :
                  mode_ff == exec_pkg::M_IMM ? operand_ff[7:0] :
                  mem_q[ea_ff[7:0]];

  shift_twos_alu shift_twos_alu_i (
    .op_in(op_ff),
    .val_in(oper_w),
    .res_out(res_w),
    .n_out(n_w),
    .z_out(z_w),
    .c_out(c_w),
    .c_upd_out(c_upd_w)
  );

  always_comb begin
    nxt_flags = flags_ff; // [RULE11]
    nxt_flags[exec_pkg::FLG_N] = n_w; // [RULE8]
    nxt_flags[exec_pkg::FLG_Z] = z_w; // [RULE9]
    nxt_flags[exec_pkg::FLG_C] = c_upd_w ? c_w : flags_ff[exec_pkg::FLG_C]; // [RULE7]
  end

  assign status_w = (32'(bytes_ff) << exec_pkg::STAT_BYTES_LSB)
                  | (32'(cyc_ff) << exec_pkg::STAT_CYC_LSB)
                  | (32'(illegal_ff) << exec_pkg::STAT_ILL_BIT)
                  | (32'(!idle_w) << exec_pkg::STAT_BUSY_BIT)
                  | (32'(result_ff) << exec_pkg::STAT_RES_LSB);

  assign rd_mux_w = avs_address_in == exec_pkg::OPCODE_OFF ? {24'h000000, opc_ff} :
                    avs_address_in == exec_pkg::OPERAND_OFF ? {16'h0000, operand_ff} :
                    avs_address_in == exec_pkg::ACC_OFF ? {24'h000000, acc_ff} :
                    avs_address_in == exec_pkg::INDEX_OFF ? {24'h000000, index_ff} :
                    avs_address_in == exec_pkg::FLAGS_OFF ? {27'h0000000, flags_ff} :
                    avs_address_in == exec_pkg::STATUS_OFF ? status_w :
                    avs_address_in == exec_pkg::MADDR_OFF ? {24'h000000, maddr_ff} :
                    avs_address_in == exec_pkg::MDATA_OFF ? {24'h000000, mem_q[maddr_ff]} :
                    32'h00000000;

  // Answer one cycle after a request is seen
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h00000000;
    end else begin
      avs_waitrequest_out <= !accept_w;
      if (accept_w) begin
        avs_readdata_out <= rd_mux_w;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff <= exec_pkg::ST_IDLE;
      cnt_ff <= 3'h0;
      op_ff <= exec_pkg::OP_NONE;
      mode_ff <= exec_pkg::M_IMM;
      ea_ff <= 16'h0000;
      opc_ff <= exec_pkg::OPCODE_RST;
    end else if (go_w) begin
      state_ff <= exec_pkg::ST_EXEC;
      cnt_ff <= dec_cyc - 3'h1; // [RULE2] [RULE5] [RULE10]
      op_ff <= dec_op;
      mode_ff <= dec_mode;
      ea_ff <= ea_w; // [RULE11]
      opc_ff <= avs_writedata_in[7:0];
    end else if (commit_w) begin
      state_ff <= exec_pkg::ST_IDLE;
    end else if (!idle_w) begin
      cnt_ff <= cnt_ff - 3'h1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      illegal_ff <= 1'b0;
      bytes_ff <= 2'h0;
      cyc_ff <= 3'h0;
      result_ff <= 8'h00;
    end else if (start_w) begin
      illegal_ff <= !dec_legal;
      bytes_ff <= dec_bytes;
      cyc_ff <= dec_cyc;
    end else if (commit_w) begin
      result_ff <= res_w;
    end
  end

  // Busy length, read by a check and by nothing else
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      run_len_ff <= 3'h0;
    end else begin
      run_len_ff <= idle_w ? 3'h0 : run_len_ff + 3'h1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_ff <= exec_pkg::ACC_RST;
    end else if (to_acc_w) begin
      acc_ff <= res_w;
    end else if (wr0_w && avs_address_in == exec_pkg::ACC_OFF) begin
      acc_ff <= avs_writedata_in[7:0];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      index_ff <= exec_pkg::INDEX_RST;
    end else if (to_idx_w) begin
      index_ff <= res_w; // [RULE1]
    end else if (wr0_w && avs_address_in == exec_pkg::INDEX_OFF) begin
      index_ff <= avs_writedata_in[7:0];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flags_ff <= exec_pkg::FLAGS_RST;
    end else if (commit_w) begin
      flags_ff <= nxt_flags;
    end else if (wr0_w && avs_address_in == exec_pkg::FLAGS_OFF) begin
      flags_ff <= avs_writedata_in[4:0];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      operand_ff <= exec_pkg::OPERAND_RST;
      maddr_ff <= exec_pkg::MADDR_RST;
    end else begin
      if (wr0_w && avs_address_in == exec_pkg::OPERAND_OFF) begin
        operand_ff[7:0] <= avs_writedata_in[7:0];
      end
      if (wr1_w && avs_address_in == exec_pkg::OPERAND_OFF) begin
        operand_ff[15:8] <= avs_writedata_in[15:8];
      end
      if (wr0_w && avs_address_in == exec_pkg::MADDR_OFF) begin
        maddr_ff <= avs_writedata_in[7:0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (to_mem_w) begin
      mem_q[ea_ff[7:0]] <= res_w; // [RULE11]
    end else if (wr0_w && avs_address_in == exec_pkg::MDATA_OFF) begin
      mem_q[maddr_ff] <= avs_writedata_in[7:0];
    end
  end

  index_load_a: assert property ( // [RULE1]
    @(posedge clk_in) disable iff (!resetn_in)
    commit_w && is_load_w |=> index_ff == $past(oper_w) &&
      flags_ff[exec_pkg::FLG_C] == $past(flags_ff[exec_pkg::FLG_C]))
    else $error("index load wrong or carry touched");

  busy_length_a: assert property ( // [RULE2]
    @(posedge clk_in) disable iff (!resetn_in)
    idle_w && $past(!idle_w) |-> run_len_ff == cyc_ff)
    else $error("busy length differs from cycle count");

  load_imm_dec_a: assert property ( // [RULE2]
    @(posedge clk_in) disable iff (!resetn_in)
    go_w && avs_writedata_in[7:0] == {exec_pkg::HI_IMM, exec_pkg::LD_LO}
      |=> !idle_w ##1 !idle_w ##1 idle_w && bytes_ff == exec_pkg::TWO_BYTES)
    else $error("immediate load timing wrong");

  shift_carry_a: assert property ( // [RULE3]
    @(posedge clk_in) disable iff (!resetn_in)
    commit_w && op_ff == exec_pkg::OP_SHIFT |=>
      result_ff == {$past(oper_w[6:0]), 1'b0} &&
      flags_ff[exec_pkg::FLG_C] == $past(oper_w[7]))
    else $error("shift result or carry wrong");

  shift_decode_a: assert property ( // [RULE5]
    @(posedge clk_in) disable iff (!resetn_in)
    start_w && avs_writedata_in[7:0] == {exec_pkg::HI_RMW_IX8, exec_pkg::SHL_LO}
      |-> dec_op == exec_pkg::OP_SHIFT && dec_cyc == 3'h6 && dec_bytes == 2'h2)
    else $error("indexed shift decode wrong");

  twos_value_a: assert property ( // [RULE6]
    @(posedge clk_in) disable iff (!resetn_in)
    commit_w && op_ff == exec_pkg::OP_TWOS |=> result_ff + $past(oper_w) == 8'h00)
    else $error("negate result wrong");

  twos_carry_a: assert property ( // [RULE7]
    @(posedge clk_in) disable iff (!resetn_in)
    commit_w && op_ff == exec_pkg::OP_TWOS |=>
      flags_ff[exec_pkg::FLG_C] == ($past(oper_w) != 8'h00))
    else $error("negate borrow wrong");

  neg_flag_a: assert property ( // [RULE8]
    @(posedge clk_in) disable iff (!resetn_in)
    commit_w |=> flags_ff[exec_pkg::FLG_N] == result_ff[7])
    else $error("negative flag wrong");

  zero_flag_a: assert property ( // [RULE9]
    @(posedge clk_in) disable iff (!resetn_in)
    commit_w |=> flags_ff[exec_pkg::FLG_Z] == (result_ff == 8'h00))
    else $error("zero flag wrong");

  twos_decode_a: assert property ( // [RULE10]
    @(posedge clk_in) disable iff (!resetn_in)
    start_w && avs_writedata_in[7:0] == {exec_pkg::HI_RMW_DIR, exec_pkg::TWOS_LO}
      |-> dec_op == exec_pkg::OP_TWOS && dec_cyc == 3'h5 && dec_bytes == 2'h2)
    else $error("direct negate decode wrong");

  mem_writeback_a: assert property ( // [RULE11]
    @(posedge clk_in) disable iff (!resetn_in)
    to_mem_w |=> mem_q[$past(ea_ff[7:0])] == result_ff &&
      flags_ff[exec_pkg::FLG_H] == $past(flags_ff[exec_pkg::FLG_H]) &&
      flags_ff[exec_pkg::FLG_I] == $past(flags_ff[exec_pkg::FLG_I]))
    else $error("write back or mask bits wrong");

endmodule : exec_slice

// >>> design/opcode_decode.sv
module opcode_decode (
  input logic [7:0] opc_in,
  output exec_pkg::op_t op_out,
  output exec_pkg::mode_t mode_out,
  output logic [1:0] bytes_out,
  output logic [2:0] cyc_out,
  output logic legal_out
);

  wire [3:0] hi_w = opc_in[7:4];
  wire [3:0] lo_w = opc_in[3:0];
  wire ld_hi_w = hi_w >= exec_pkg::HI_IMM;
  wire rmw_hi_w = hi_w >= exec_pkg::HI_RMW_DIR && hi_w <= exec_pkg::HI_RMW_IX0;
  wire is_ld_w = ld_hi_w && lo_w == exec_pkg::LD_LO;
  wire is_shl_w = rmw_hi_w && lo_w == exec_pkg::SHL_LO;
  wire is_twos_w = rmw_hi_w && lo_w == exec_pkg::TWOS_LO;

  assign legal_out = is_ld_w || is_shl_w || is_twos_w;
  assign op_out = is_ld_w ? exec_pkg::OP_LOAD : // [RULE2]
                  is_shl_w ? exec_pkg::OP_SHIFT : // [RULE4] [RULE5]
                  is_twos_w ? exec_pkg::OP_TWOS : exec_pkg::OP_NONE; // [RULE10]

  always_comb begin
    unique case (hi_w)
      exec_pkg::HI_IMM: mode_out = exec_pkg::M_IMM;
      exec_pkg::HI_DIR: mode_out = exec_pkg::M_DIR;
      exec_pkg::HI_EXT: mode_out = exec_pkg::M_EXT;
      exec_pkg::HI_IX16: mode_out = exec_pkg::M_IX16;
      exec_pkg::HI_IX8: mode_out = exec_pkg::M_IX8;
      exec_pkg::HI_IX0: mode_out = exec_pkg::M_IX0;
      exec_pkg::HI_RMW_DIR: mode_out = exec_pkg::M_DIR;
      exec_pkg::HI_ACC: mode_out = exec_pkg::M_ACC;
      exec_pkg::HI_IDX: mode_out = exec_pkg::M_IDX;
      exec_pkg::HI_RMW_IX8: mode_out = exec_pkg::M_IX8;
      exec_pkg::HI_RMW_IX0: mode_out = exec_pkg::M_IX0;
      default: mode_out = exec_pkg::M_IMM;
    endcase
  end

  always_comb begin
    unique case (mode_out)
      exec_pkg::M_IMM: cyc_out = exec_pkg::LD_IMM_CYC; // [RULE2]
      exec_pkg::M_DIR: cyc_out = is_ld_w ? exec_pkg::LD_DIR_CYC : exec_pkg::RMW_DIR_CYC;
      exec_pkg::M_EXT: cyc_out = exec_pkg::LD_EXT_CYC;
      exec_pkg::M_IX0: cyc_out = is_ld_w ? exec_pkg::LD_IX0_CYC : exec_pkg::RMW_IX0_CYC;
      exec_pkg::M_IX8: cyc_out = is_ld_w ? exec_pkg::LD_IX8_CYC : exec_pkg::RMW_IX8_CYC;
      exec_pkg::M_IX16: cyc_out = exec_pkg::LD_IX16_CYC;
      exec_pkg::M_ACC: cyc_out = exec_pkg::RMW_REG_CYC; // [RULE5] [RULE10]
      exec_pkg::M_IDX: cyc_out = exec_pkg::RMW_REG_CYC;
    endcase
  end

  always_comb begin
    unique case (mode_out)
      exec_pkg::M_IMM: bytes_out = exec_pkg::TWO_BYTES;
      exec_pkg::M_DIR: bytes_out = exec_pkg::TWO_BYTES;
      exec_pkg::M_EXT: bytes_out = exec_pkg::THREE_BYTES;
      exec_pkg::M_IX0: bytes_out = exec_pkg::ONE_BYTE;
      exec_pkg::M_IX8: bytes_out = exec_pkg::TWO_BYTES;
      exec_pkg::M_IX16: bytes_out = exec_pkg::THREE_BYTES;
      exec_pkg::M_ACC: bytes_out = exec_pkg::ONE_BYTE;
      exec_pkg::M_IDX: bytes_out = exec_pkg::ONE_BYTE;
    endcase
  end

endmodule : opcode_decode

// >>> design/shift_twos_alu.sv
module shift_twos_alu (
  input exec_pkg::op_t op_in,
  input logic [7:0] val_in,
  output logic [7:0] res_out,
  output logic n_out,
  output logic z_out,
  output logic c_out,
  output logic c_upd_out
);

  // One shift path serves both shift names
  wire [7:0] shl_w = {val_in[6:0], 1'b0}; // [RULE3] [RULE4]
  wire [7:0] twos_w = 8'h00 - val_in; // [RULE6]

  assign res_out = op_in == exec_pkg::OP_SHIFT ? shl_w :
                   op_in == exec_pkg::OP_TWOS ? twos_w : val_in; // [RULE1]
  assign n_out = res_out[7]; // [RULE8]
  assign z_out = exec_pkg::is_zero(res_out); // [RULE9]
  assign c_out = op_in == exec_pkg::OP_SHIFT ? val_in[7] : !exec_pkg::is_zero(val_in); // [RULE3] [RULE7]
  // Load leaves carry alone
  assign c_upd_out = op_in == exec_pkg::OP_SHIFT || op_in == exec_pkg::OP_TWOS; // [RULE1]

endmodule : shift_twos_alu

// >>> tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic [31:0] v; logic [31:0] m;} note_t;

  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [4:0] avs_address_in = 5'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h00000000;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  int fails = 0;
  int compares = 0;
  int seed = 32'h5e33;
  note_t notes[$];
  note_t nt;
  // Opcode, length, cycle count
  logic [12:0] tbl [16] = '{
    {8'hae, 2'h2, 3'h2}, {8'hbe, 2'h2, 3'h3}, {8'hce, 2'h3, 3'h4}, {8'hfe, 2'h1, 3'h3},
    {8'hee, 2'h2, 3'h4}, {8'hde, 2'h3, 3'h5}, {8'h48, 2'h1, 3'h3}, {8'h58, 2'h1, 3'h3},
    {8'h38, 2'h2, 3'h5}, {8'h78, 2'h1, 3'h5}, {8'h68, 2'h2, 3'h6}, {8'h40, 2'h1, 3'h3},
    {8'h50, 2'h1, 3'h3}, {8'h30, 2'h2, 3'h5}, {8'h70, 2'h1, 3'h5}, {8'h60, 2'h2, 3'h6}};
  logic [7:0] edge_v [4] = '{8'h00, 8'h80, 8'hff, 8'h01};

  exec_slice exec_slice_i (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out)
  );

  always #4 clk_in = ~clk_in;

  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic hang();
    fails++;
    $display("unexpected hang at %0t: %h %h", $time, 1'b0, 1'b1);
    end_sim();
  endtask : hang

  // Request held until waitrequest is seen low; one idle edge keeps drivers single-assigned
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_write_in <= w;
    avs_read_in <= ~w;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 100);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (avs_waitrequest_out !== 1'b0) begin
      hang();
    end
    @(posedge clk_in);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    notes.push_back('{e, m});
    bus(1'b0, a, 32'h00000000, 4'hf, q);
  endtask : rd

  task automatic poll();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      notes.push_back('{32'h00000000, 32'h00000000});
      bus(1'b0, exec_pkg::STATUS_OFF, 32'h00000000, 4'hf, q);
      n++;
    end while (q[exec_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 20);
    if (q[exec_pkg::STAT_BUSY_BIT] !== 1'b0) begin
      hang();
    end
  endtask : poll

  // Reads are judged at the acknowledging edge, against the oldest note
  always @(posedge clk_in) begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0) begin
      if (notes.size() == 0) begin
        fails++;
        $display("unexpected read at %0t: %h %h", $time, avs_readdata_out, 32'h0);
      end else begin
        nt = notes.pop_front();
        if (nt.m != 32'h00000000) begin
          compares++;
          if ((avs_readdata_out & nt.m) !== (nt.v & nt.m)) begin
            fails++;
            $display("unexpected value at %0t: got %h expected %h", $time,
              avs_readdata_out & nt.m, nt.v & nt.m);
          end
        end
      end
    end
  end

  // Random state around each operation exposes flags or the accumulator wrongly touched
  task automatic exec_case(input logic [12:0] t, input logic [7:0] v);
    logic [7:0] opc;
    logic [7:0] idx;
    logic [7:0] acc;
    logic [7:0] ea;
    logic [7:0] res;
    logic [15:0] opnd;
    logic [4:0] fl;
    logic c;
    opc = t[12:5];
    idx = 8'($random(seed));
    acc = 8'($random(seed));
    opnd = 16'($random(seed));
    fl = 5'($random(seed));
    if (opc[7:4] == 4'h5) idx = v;
    if (opc[7:4] == 4'h4) acc = v;
    if (opc[7:4] == 4'ha) opnd[7:0] = v;
    case (opc[7:4])
      4'hf, 4'h7: ea = idx;
      4'he, 4'h6, 4'hd: ea = idx + opnd[7:0];
      default: ea = opnd[7:0];
    endcase
    case (opc[3:0])
      4'he: begin
        res = v;
        c = fl[0];
      end
      4'h8: begin
        res = {v[6:0], 1'b0};
        c = v[7];
      end
      default: begin
        res = 8'h00 - v;
        c = (v != 8'h00);
      end
    endcase
    wr(exec_pkg::ACC_OFF, {24'h000000, acc});
    wr(exec_pkg::INDEX_OFF, {24'h000000, idx});
    wr(exec_pkg::OPERAND_OFF, {16'h0000, opnd});
    wr(exec_pkg::FLAGS_OFF, {27'h0000000, fl});
    wr(exec_pkg::MADDR_OFF, {24'h000000, ea});
    wr(exec_pkg::MDATA_OFF, {24'h000000, v});
    wr(exec_pkg::OPCODE_OFF, {24'h000000, opc});
    poll();
    rd(exec_pkg::FLAGS_OFF, {27'h0, fl[4:3], res[7], res == 8'h00, c}, 32'h1f);
    rd(exec_pkg::STATUS_OFF, {16'h0, res, 3'h0, t[2:0], t[4:3]}, 32'hffdf);
    rd(exec_pkg::OPCODE_OFF, {24'h000000, opc}, 32'hff);
    if (opc[3:0] == 4'he || opc[7:4] == 4'h5) begin
      rd(exec_pkg::INDEX_OFF, {24'h000000, res}, 32'hff);
    end else if (opc[7:4] == 4'h4) begin
      rd(exec_pkg::ACC_OFF, {24'h000000, res}, 32'hff);
    end else begin
      rd(exec_pkg::MDATA_OFF, {24'h000000, res}, 32'hff);
    end
    if (opc[7:4] != 4'h4) begin
      rd(exec_pkg::ACC_OFF, {24'h000000, acc}, 32'hff);
    end
    $display("test opcode %h value %h done", opc, v);
  endtask : exec_case

  initial begin
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    rd(exec_pkg::OPCODE_OFF, {24'h0, exec_pkg::OPCODE_RST}, 32'hff);
    rd(exec_pkg::OPERAND_OFF, {16'h0, exec_pkg::OPERAND_RST}, 32'hffff);
    rd(exec_pkg::ACC_OFF, {24'h0, exec_pkg::ACC_RST}, 32'hff);
    rd(exec_pkg::INDEX_OFF, {24'h0, exec_pkg::INDEX_RST}, 32'hff);
    rd(exec_pkg::FLAGS_OFF, {27'h0, exec_pkg::FLAGS_RST}, 32'h1f);
    rd(exec_pkg::MADDR_OFF, {24'h0, exec_pkg::MADDR_RST}, 32'hff);
    rd(exec_pkg::STATUS_OFF, 32'h00000000, 32'hffff);
    rd(5'h05, 32'h00000000, 32'hffffffff);
    wr(5'h09, 32'h000000ff);
    wr(exec_pkg::ACC_OFF, 32'h0000005a, 4'h0);
    rd(exec_pkg::ACC_OFF, 32'h00000000, 32'hff);
    wr(exec_pkg::OPERAND_OFF, 32'h0000ab00, 4'h2);
    rd(exec_pkg::OPERAND_OFF, 32'h0000ab00, 32'hffff);
    $display("test reset and refusals done");
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 16; i++) begin
        exec_case(tbl[i], 8'($random(seed)));
      end
    end
    // Sign, zero and wrap corners of each operation
    for (int k = 0; k < 4; k++) begin
      exec_case(tbl[0], edge_v[k]);
      exec_case(tbl[6], edge_v[k]);
      exec_case(tbl[11], edge_v[k]);
    end
    wr(exec_pkg::OPCODE_OFF, 32'h00000041);
    poll();
    rd(exec_pkg::STATUS_OFF, 32'h00000040, 32'h000000c0);
    rd(exec_pkg::OPCODE_OFF, 32'h00000040, 32'hff);
    $display("test illegal opcode done");
    end_sim();
  end

endmodule : tb
